// ### src/dual_timer_counter.sv
// Two timer/counters with shared control register and external interrupt flags
// Operation
// (R1) Low and high bytes chain to 16 bits
// (R2) Run bit enables counting, keeps count
// (R3) Stop timer before writing preset values
// (R4) Timer ticks once per peripheral cycle
// (R5) Rate osc/12 standard, osc/6 double speed
// (R6) Counter mode counts sampled falling edges
// (R7) Count pin levels last one cycle
// (R8) Stop timer before changing mode
// (R9) Timer0 low mode nibble, Timer1 high
// (R10) Gating lets interrupt pin control counting
// (R11) Rollover sets overflow flag, requests interrupt
// (R12) Mode 0: 13-bit with 5-bit prescaler
// (R13) Mode 1: cascaded 16-bit counter
// (R14) Mode 2: 8-bit auto-reload from high
// (R15) Timer1 mode 3 halts and holds
// (R16) Timer0 mode 3 borrows Timer1 run, flag
// (R17) Overflow flag cleared on vectoring
// (R18) Interrupt needs individual and global enable; external requests here are gated by the global enable only
// (R19) Type bit: low-level or falling edge
// (R20) Pending flag set; edge cleared on service
// (R21) Control register layout, resets zero
// (R22) Split mode: two 8-bit timers
// (R23) Gated count only while pin high
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter
    import tmr_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    // Special function register port
    input  wire logic [7:0]  i_sfr_addr,
    input  wire logic        i_sfr_wr,
    input  wire logic [7:0]  i_sfr_wdata,
    input  wire logic        i_sfr_rd,
    output logic      [7:0]  o_sfr_rdata,
    // Clock speed and interrupt enables
    input  wire logic        i_double_speed_clock_mode,
    input  wire logic        i_global_interrupt_enable,
    input  wire logic [1:0]  i_timer_irq_enable,
    // Interrupt vectoring acknowledges: 0 timer0, 1 timer1, 2 ext0, 3 ext1
    input  wire logic [3:0]  i_irq_vector_ack,
    // External pins
    input  wire logic [1:0]  i_count_pin,
    input  wire logic        i_ext_irq0_pin_n,
    input  wire logic        i_ext_irq1_pin_n,
    // Interrupt requests
    output logic [1:0]       o_timer_irq,
    output logic [1:0]       o_ext_irq
);
    //--------------------------------------------------------------
    // Registers
    //--------------------------------------------------------------
    logic [7:0] timer_ext_irq_control_reg;
    logic [7:0] timer_ext_irq_control_next;
    logic [7:0] timer_mode_register_reg;
    logic [7:0] low_reg  [2];
    logic [7:0] low_next [2];
    logic [7:0] high_reg [2];
    logic [7:0] high_next[2];
    logic [1:0] cnt_pin_d_reg;
    logic [1:0] irq_pin_d_reg;
    logic [1:0] irq_pin_n;

    tick_if tk();

    cycle_divider u_div
    (
        .i_clk          (i_clk),
        .i_resetn       (i_resetn),
        .i_double_speed (i_double_speed_clock_mode),
        .tk             (tk.source)
    );

    //--------------------------------------------------------------
    // Decode
    //--------------------------------------------------------------
    wire wr_ctl  = i_sfr_wr && (i_sfr_addr == OFS_CONTROL);
    wire wr_mode = i_sfr_wr && (i_sfr_addr == OFS_MODE);
    wire [1:0] wr_low  = {i_sfr_wr && (i_sfr_addr == OFS_T1_LOW),  i_sfr_wr && (i_sfr_addr == OFS_T0_LOW)};
    wire [1:0] wr_high = {i_sfr_wr && (i_sfr_addr == OFS_T1_HIGH), i_sfr_wr && (i_sfr_addr == OFS_T0_HIGH)};

    assign irq_pin_n = {i_ext_irq1_pin_n, i_ext_irq0_pin_n};

    wire [3:0] nib0 = timer_mode_register_reg[3:0];                     // (R9)
    wire [3:0] nib1 = timer_mode_register_reg[T1_NIBBLE +: 4];          // (R9)
    wire [1:0] mode0 = {nib0[MODE_HI], nib0[MODE_LO]};
    wire [1:0] mode1 = {nib1[MODE_HI], nib1[MODE_LO]};
    wire       split = (mode0 == MODE_SPLIT);

    wire run0 = timer_ext_irq_control_reg[CTL_T0_RUN];
    wire run1 = timer_ext_irq_control_reg[CTL_T1_RUN];

    // Enable: run alone, or run with pin high when gated
    function automatic logic gate_ok(input logic run, input logic gate, input logic pin_n);
        gate_ok = run && (!gate || pin_n);                              // (R10) (R23)
    endfunction

    // Count event: peripheral tick, or sampled falling edge in counter mode
    function automatic logic count_evt(input logic csel, input logic now, input logic prev, input logic tick);
        count_evt = tick && (csel ? (prev && !now) : 1'b1);             // (R4) (R6)
    endfunction

    wire [1:0] ev;
    assign ev[0] = count_evt(nib0[MODE_CSEL], i_count_pin[0], cnt_pin_d_reg[0], tk.tick);
    assign ev[1] = count_evt(nib1[MODE_CSEL], i_count_pin[1], cnt_pin_d_reg[1], tk.tick);

    wire en0  = gate_ok(run0, nib0[MODE_GATE], irq_pin_n[0]) && ev[0]; // (R2)
    // Timer0 high byte in split mode borrows Timer1 run bit
    wire en0h = run1 && tk.tick;                                        // (R22)
    // Timer1 ignores its run bit while Timer0 has taken it
    wire en1  = (split ? 1'b1 : gate_ok(run1, nib1[MODE_GATE], irq_pin_n[1])) && ev[1]
                && (mode1 != MODE_SPLIT);                               // (R15) (R16)

    //--------------------------------------------------------------
    // Counting
    //--------------------------------------------------------------
    logic [1:0] ovf;
    logic       ovf0h;

    always_comb
    begin
        logic [1:0] m [2];
        logic [1:0] en;
        m[0] = mode0;
        m[1] = mode1;
        en   = {en1, en0};
        ovf   = 2'b00;
        ovf0h = 1'b0;
        for (int t = 0; t < 2; t++)
        begin
            low_next[t]  = low_reg[t];
            high_next[t] = high_reg[t];
            if (en[t])
            begin
                unique case (m[t])
                    MODE_13BIT:
                    begin
                        low_next[t][4:0] = low_reg[t][4:0] + 5'h01;      // (R12)
                        if (low_reg[t][4:0] == PRESC13_LAST)
                        begin
                            high_next[t] = high_reg[t] + 8'h01;
                            ovf[t]       = (high_reg[t] == 8'hFF);      // (R11)
                        end
                    end
                    MODE_16BIT:
                    begin
                        low_next[t] = low_reg[t] + 8'h01;               // (R1) (R13)
                        if (low_reg[t] == 8'hFF)
                        begin
                            high_next[t] = high_reg[t] + 8'h01;
                            ovf[t]       = (high_reg[t] == 8'hFF);      // (R11)
                        end
                    end
                    MODE_RELOAD:
                    begin
                        if (low_reg[t] == 8'hFF)
                        begin
                            low_next[t] = high_reg[t];                  // (R14)
                            ovf[t]      = 1'b1;
                        end
                        else
                            low_next[t] = low_reg[t] + 8'h01;
                    end
                    MODE_SPLIT:
                    begin
                        // Only Timer0 reaches here; low byte is a plain 8-bit timer
                        low_next[t] = low_reg[t] + 8'h01;               // (R22)
                        ovf[t]      = (low_reg[t] == 8'hFF);
                    end
                endcase
            end
        end
        if (split && en0h)
        begin
            high_next[0] = high_reg[0] + 8'h01;                         // (R22)
            ovf0h        = (high_reg[0] == 8'hFF);
        end
        // Processor preset writes
        for (int t = 0; t < 2; t++)
        begin
            if (wr_low[t])
                low_next[t] = i_sfr_wdata;                              // (R3)
            if (wr_high[t])
                high_next[t] = i_sfr_wdata;
        end
    end

    //--------------------------------------------------------------
    // Control register and flags
    //--------------------------------------------------------------
    wire [1:0] irq_fall  = irq_pin_d_reg & ~irq_pin_n;
    wire [1:0] irq_typ   = {timer_ext_irq_control_reg[CTL_IRQ1_TYP], timer_ext_irq_control_reg[CTL_IRQ0_TYP]};
    wire [1:0] irq_det   = (irq_typ & irq_fall) | (~irq_typ & ~irq_pin_n); // (R19)
    // Timer1 overflow flag belongs to Timer0's high byte in split mode
    wire       set_tf1   = split ? ovf0h : ovf[1];                      // (R16)
    wire       set_tf0   = ovf[0];

    always_comb
    begin
        timer_ext_irq_control_next = timer_ext_irq_control_reg;
        if (wr_ctl)
            timer_ext_irq_control_next = i_sfr_wdata;
        // Hardware clears on vectoring; sets win over any clear
        if (i_irq_vector_ack[0])
            timer_ext_irq_control_next[CTL_T0_OVF] = 1'b0;              // (R17)
        if (i_irq_vector_ack[1])
            timer_ext_irq_control_next[CTL_T1_OVF] = 1'b0;              // (R17)
        if (i_irq_vector_ack[2] && irq_typ[0])
            timer_ext_irq_control_next[CTL_IRQ0_PND] = 1'b0;            // (R20)
        if (i_irq_vector_ack[3] && irq_typ[1])
            timer_ext_irq_control_next[CTL_IRQ1_PND] = 1'b0;            // (R20)
        // Level mode follows the pin
        if (!irq_typ[0])
            timer_ext_irq_control_next[CTL_IRQ0_PND] = irq_det[0];      // (R19)
        if (!irq_typ[1])
            timer_ext_irq_control_next[CTL_IRQ1_PND] = irq_det[1];      // (R19)
        if (set_tf0)
            timer_ext_irq_control_next[CTL_T0_OVF] = 1'b1;              // (R11)
        if (set_tf1)
            timer_ext_irq_control_next[CTL_T1_OVF] = 1'b1;              // (R11)
        if (irq_det[0])
            timer_ext_irq_control_next[CTL_IRQ0_PND] = 1'b1;            // (R20)
        if (irq_det[1])
            timer_ext_irq_control_next[CTL_IRQ1_PND] = 1'b1;            // (R20)
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            timer_ext_irq_control_reg <= RST_CONTROL;                   // (R21)
            timer_mode_register_reg   <= RST_MODE;
            cnt_pin_d_reg             <= 2'b00;
            irq_pin_d_reg             <= 2'b11;
        end
        else
        begin
            timer_ext_irq_control_reg <= timer_ext_irq_control_next;
            if (wr_mode)
                timer_mode_register_reg <= i_sfr_wdata;                 // (R8)
            // Count pins sampled once per peripheral cycle
            if (tk.tick)
                cnt_pin_d_reg <= i_count_pin;                           // (R6) (R7)
            irq_pin_d_reg <= irq_pin_n;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            for (int t = 0; t < 2; t++)
            begin
                low_reg[t]  <= RST_COUNT;
                high_reg[t] <= RST_COUNT;
            end
        end
        else
        begin
            for (int t = 0; t < 2; t++)
            begin
                low_reg[t]  <= low_next[t];
                high_reg[t] <= high_next[t];
            end
        end
    end

    //--------------------------------------------------------------
    // Read back and interrupt outputs
    //--------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb
    begin
        unique case (i_sfr_addr)
            OFS_CONTROL: rd_mux = timer_ext_irq_control_reg;            // (R21)
            OFS_MODE:    rd_mux = timer_mode_register_reg;
            OFS_T0_LOW:  rd_mux = low_reg[0];
            OFS_T1_LOW:  rd_mux = low_reg[1];
            OFS_T0_HIGH: rd_mux = high_reg[0];
            OFS_T1_HIGH: rd_mux = high_reg[1];
            default:     rd_mux = 8'h00;
        endcase
    end

    wire [1:0] tf = {timer_ext_irq_control_next[CTL_T1_OVF], timer_ext_irq_control_next[CTL_T0_OVF]};
    wire [1:0] ie = {timer_ext_irq_control_next[CTL_IRQ1_PND], timer_ext_irq_control_next[CTL_IRQ0_PND]};

    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            o_sfr_rdata <= 8'h00;
            o_timer_irq <= 2'b00;
            o_ext_irq   <= 2'b00;
        end
        else
        begin
            if (i_sfr_rd)
                o_sfr_rdata <= rd_mux;
            o_timer_irq <= tf & i_timer_irq_enable & {2{i_global_interrupt_enable}}; // (R18)
            o_ext_irq   <= ie & {2{i_global_interrupt_enable}};
        end
    end
endmodule // dual_timer_counter
`default_nettype wire

// ### inc/tmr_pkg.sv
// Package: register offsets, field positions, reset values and timing constants of the dual timer block
package tmr_pkg;
    // Register offsets (SFR addresses)
    localparam logic [7:0] OFS_CONTROL  = 8'h88;
    localparam logic [7:0] OFS_MODE     = 8'h89;
    localparam logic [7:0] OFS_T0_LOW   = 8'h8A;
    localparam logic [7:0] OFS_T1_LOW   = 8'h8B;
    localparam logic [7:0] OFS_T0_HIGH  = 8'h8C;
    localparam logic [7:0] OFS_T1_HIGH  = 8'h8D;
    // Control register fields
    localparam int CTL_T1_OVF   = 7;
    localparam int CTL_T1_RUN   = 6;
    localparam int CTL_T0_OVF   = 5;
    localparam int CTL_T0_RUN   = 4;
    localparam int CTL_IRQ1_PND = 3;
    localparam int CTL_IRQ1_TYP = 2;
    localparam int CTL_IRQ0_PND = 1;
    localparam int CTL_IRQ0_TYP = 0;
    // Mode register field positions within a timer nibble
    localparam int MODE_GATE    = 3;
    localparam int MODE_CSEL    = 2;
    localparam int MODE_HI      = 1;
    localparam int MODE_LO      = 0;
    localparam int T1_NIBBLE    = 4;
    // Reset values
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_MODE    = 8'h00;
    localparam logic [7:0] RST_COUNT   = 8'h00;
    // Oscillator periods per peripheral cycle, standard and double speed
    localparam int OSC_PER_CYCLE_STD = 12;
    localparam int OSC_PER_CYCLE_X2  = 6;
    localparam int PRESC_W           = 4;
    localparam logic [PRESC_W-1:0] PRESC_STD_LAST = PRESC_W'(OSC_PER_CYCLE_STD - 1);
    localparam logic [PRESC_W-1:0] PRESC_X2_LAST  = PRESC_W'(OSC_PER_CYCLE_X2 - 1);
    // Mode codes
    localparam logic [1:0] MODE_13BIT = 2'h0;
    localparam logic [1:0] MODE_16BIT = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;
    localparam logic [4:0] PRESC13_LAST = 5'h1F;
endpackage

// ### inc/tick_if.sv
// Interface: peripheral-cycle tick between the cycle divider and the timers
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
    logic tick;
    modport source (output tick);
    modport sink   (input  tick);
endinterface
`default_nettype wire

// ### src/cycle_divider.sv
// Peripheral-cycle divider producing one tick per 12 or 6 oscillator periods
`timescale 1ns/1ps
`default_nettype none
module cycle_divider
    import tmr_pkg::*;
(
    // Clock and reset
    input  wire logic   i_clk,
    input  wire logic   i_resetn,
    // Speed select
    input  wire logic   i_double_speed,
    // Tick out
    tick_if.source      tk
);
    logic [PRESC_W-1:0] cnt_reg;
    logic [PRESC_W-1:0] cnt_next;
    wire  [PRESC_W-1:0] last = i_double_speed ? PRESC_X2_LAST : PRESC_STD_LAST; // (R5)
    wire                wrap = (cnt_reg >= last);

    assign cnt_next = wrap ? '0 : cnt_reg + PRESC_W'(1);

    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_next;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
            tk.tick <= 1'b0;
        else
            tk.tick <= wrap; // (R4)
    end
endmodule // cycle_divider
`default_nettype wire

// ### sim/dual_timer_counter_chk.sv
// Checker: port-level assertions for the dual timer block
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter_chk
    import tmr_pkg::*;
(
    input wire logic       i_clk,
    input wire logic       i_resetn,
    input wire logic [7:0] i_sfr_addr,
    input wire logic       i_sfr_wr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic       i_sfr_rd,
    input wire logic [7:0] o_sfr_rdata,
    input wire logic       i_double_speed_clock_mode,
    input wire logic       i_global_interrupt_enable,
    input wire logic [1:0] i_timer_irq_enable,
    input wire logic [3:0] i_irq_vector_ack,
    input wire logic [1:0] i_count_pin,
    input wire logic       i_ext_irq0_pin_n,
    input wire logic       i_ext_irq1_pin_n,
    input wire logic [1:0] o_timer_irq,
    input wire logic [1:0] o_ext_irq
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    // ----
    // Assertions
    // ----
    chk_t0_irq_gate: assert property (!i_timer_irq_enable[0] |=> !o_timer_irq[0])
        else $error("timer 0 request while disabled");
    chk_t1_irq_gate: assert property (!i_timer_irq_enable[1] |=> !o_timer_irq[1])
        else $error("timer 1 request while disabled");
    chk_global_timer_gate: assert property (!i_global_interrupt_enable |=> o_timer_irq == 2'h0)
        else $error("timer request without global enable");
    chk_global_ext_gate: assert property (!i_global_interrupt_enable |=> o_ext_irq == 2'h0)
        else $error("external request without global enable");
    chk_read_hold: assert property (!i_sfr_rd |=> $stable(o_sfr_rdata))
        else $error("read data moved without a read");
    chk_unmapped_read: assert property (i_sfr_rd && (i_sfr_addr < OFS_CONTROL || i_sfr_addr > OFS_T1_HIGH)
        |=> o_sfr_rdata == 8'h00) else $error("unmapped read not zero");
    chk_mode_readback: assert property (i_sfr_wr && i_sfr_addr == OFS_MODE ##1 i_sfr_rd && !i_sfr_wr
        && i_sfr_addr == OFS_MODE |=> o_sfr_rdata == $past(i_sfr_wdata, 2)) else $error("mode readback");
    chk_ctl_soft_bits: assert property (i_sfr_wr && i_sfr_addr == OFS_CONTROL ##1 i_sfr_rd && !i_sfr_wr
        && i_sfr_addr == OFS_CONTROL |=> (o_sfr_rdata & 8'h55) == ($past(i_sfr_wdata, 2) & 8'h55))
        else $error("control run or type bits lost");
endmodule // dual_timer_counter_chk
bind dual_timer_counter dual_timer_counter_chk u_dual_timer_counter_chk (.i_clk, .i_resetn, .i_sfr_addr,
    .i_sfr_wr, .i_sfr_wdata, .i_sfr_rd, .o_sfr_rdata, .i_double_speed_clock_mode, .i_global_interrupt_enable,
    .i_timer_irq_enable, .i_irq_vector_ack, .i_count_pin, .i_ext_irq0_pin_n, .i_ext_irq1_pin_n, .o_timer_irq,
    .o_ext_irq);
`default_nettype wire

// ### sim/count_pin_model.sv
// Partner: external count pin source producing three falling edges per request
`timescale 1ns/1ps
`default_nettype none
module count_pin_model
(
    // Clock and request
    input  wire logic       i_clk,
    input  wire logic [1:0] i_start,
    input  wire logic [7:0] i_hold,
    // Pins and status
    output var logic  [1:0] o_count_pin,
    output var logic        o_busy
);
    logic [1:0] sel;
    // ----
    // Pulse train, idle level high as with a pull-up
    // ----
    initial
    begin
        o_count_pin = 2'h3;
        o_busy = 1'b0;
        forever
        begin
            @(posedge i_clk);
            if (i_start != 2'h0)
            begin
                o_busy = 1'b1;
                sel = i_start;
                repeat (3)
                begin
                    #1 o_count_pin = ~sel;
                    repeat (i_hold) @(posedge i_clk);
                    #1 o_count_pin = 2'h3;
                    repeat (i_hold) @(posedge i_clk);
                end
                // Busy falls i_hold clocks after the last return to high, well after the last falling edge is sampled
                o_busy = 1'b0;
            end
        end
    end
endmodule // count_pin_model
`default_nettype wire

// ### sim/dual_timer_counter_tb_top.sv
// Testbench: scenario tasks for the dual timer block
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter_tb_top
    import tmr_pkg::*;
;
    logic       i_clk = 0, i_resetn = 0, sfr_wr = 0, sfr_rd = 0, dspd = 0, glob = 0;
    logic [7:0] addr = 0, wdata = 0, hold = 8'h0C;
    logic [1:0] ten = 0, start = 0, irq_n = 2'h3;
    logic [3:0] ack = 0;
    wire  [7:0] rdata;
    wire  [1:0] pins, tirq, eirq;
    wire        busy;
    int         failures = 0, tests_run = 0;
    always #50 i_clk = ~i_clk;
    dual_timer_counter u_dual_timer_counter (.i_clk(i_clk), .i_resetn(i_resetn), .i_sfr_addr(addr),
        .i_sfr_wr(sfr_wr), .i_sfr_wdata(wdata), .i_sfr_rd(sfr_rd), .o_sfr_rdata(rdata),
        .i_double_speed_clock_mode(dspd), .i_global_interrupt_enable(glob), .i_timer_irq_enable(ten),
        .i_irq_vector_ack(ack), .i_count_pin(pins), .i_ext_irq0_pin_n(irq_n[0]), .i_ext_irq1_pin_n(irq_n[1]),
        .o_timer_irq(tirq), .o_ext_irq(eirq));
    count_pin_model u_count_pin_model (.i_clk(i_clk), .i_start(start), .i_hold(hold), .o_count_pin(pins),
        .o_busy(busy));
    // ----
    // Bus and checking tasks
    // ----
    task tally_and_finish;
        if (failures == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Waiting lowers a write strobe left up by wr, so back-to-back writes hold it high
    task cyc(input int n);
        sfr_wr = 0;
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        addr = a; wdata = d; sfr_wr = 1; @(posedge i_clk); #1;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        addr = a; sfr_rd = 1; cyc(1); sfr_rd = 0; cyc(1); chk(rdata, e);
    endtask
    // Run bit high for exactly n clock edges, so n/12 ticks are counted, n/6 at double speed
    task run_for(input logic [7:0] on, input logic [7:0] off, input int n);
        wr(OFS_CONTROL, on); cyc(n - 1); wr(OFS_CONTROL, off);
    endtask
    task preset(input logic [7:0] mode, input logic [7:0] lo, input logic [7:0] hi);
        wr(OFS_MODE, mode); wr(OFS_T0_LOW, lo); wr(OFS_T0_HIGH, hi);
    endtask
    // ----
    // Scenarios
    // ----
    task t_regs;
        for (int a = 0; a < 6; a++) rd(OFS_CONTROL + 8'(a), 8'h00);
        rd(8'h8E, 8'h00);
        wr(OFS_MODE, 8'hA5); rd(OFS_MODE, 8'hA5);
    endtask
    task t_mode1_irq;
        preset(8'h01, 8'hFE, 8'hFF);
        wr(OFS_CONTROL, 8'h10); cyc(29); rd(OFS_CONTROL, 8'h30);
        cyc(4); wr(OFS_CONTROL, 8'h20);
        rd(OFS_T0_LOW, 8'h01); rd(OFS_T0_HIGH, 8'h00);
        ten = 2'h1; cyc(2); chk(8'(tirq), 8'h00);
        glob = 1; cyc(2); chk(8'(tirq), 8'h01);
        ack[0] = 1; cyc(1); ack = 0; cyc(2); chk(8'(tirq), 8'h00);
        rd(OFS_CONTROL, 8'h00);
        dspd = 1; cyc(24); preset(8'h01, 8'h00, 8'h00);
        run_for(8'h10, 8'h00, 12); rd(OFS_T0_LOW, 8'h02);
        dspd = 0; cyc(24);
    endtask
    task t_mode0_mode2;
        preset(8'h00, 8'hFF, 8'h00); run_for(8'h10, 8'h00, 12);
        rd(OFS_T0_LOW, 8'hE0); rd(OFS_T0_HIGH, 8'h01);
        preset(8'h02, 8'hFF, 8'h80); run_for(8'h10, 8'h00, 24);
        rd(OFS_T0_LOW, 8'h81); rd(OFS_T0_HIGH, 8'h80);
    endtask
    task t_split;
        preset(8'h33, 8'h05, 8'hFF); wr(OFS_T1_LOW, 8'h11); ten = 2'h2;
        wr(OFS_CONTROL, 8'h40); cyc(14); chk(8'(tirq), 8'h02);
        ack[1] = 1; cyc(1); ack = 0; chk(8'(tirq), 8'h00);
        cyc(8); wr(OFS_CONTROL, 8'h00);
        rd(OFS_T0_HIGH, 8'h01); rd(OFS_T0_LOW, 8'h05); rd(OFS_T1_LOW, 8'h11);
    endtask
    task t_gate;
        preset(8'h09, 8'h00, 8'h00); irq_n[0] = 0;
        run_for(8'h10, 8'h00, 24); rd(OFS_T0_LOW, 8'h00);
        irq_n[0] = 1; run_for(8'h10, 8'h00, 24); rd(OFS_T0_LOW, 8'h02);
    endtask
    task t_counter;
        wr(OFS_MODE, 8'h50); wr(OFS_T1_LOW, 8'h00); wr(OFS_T1_HIGH, 8'h00); wr(OFS_CONTROL, 8'h40);
        for (int h = 12; h <= 20; h += 8)
        begin
            hold = 8'(h); start = 2'h2; cyc(1); start = 0;
            for (int i = 0; i < 400 && busy; i++) cyc(1);
            if (busy)
            begin
                failures++;
                tally_and_finish();
            end
            cyc(12);
        end
        wr(OFS_CONTROL, 8'h00); rd(OFS_T1_LOW, 8'h06);
    endtask
    task t_ext;
        for (int k = 0; k < 2; k++)
        begin
            wr(OFS_CONTROL, 8'h00); irq_n[k] = 0; cyc(4); chk(8'(eirq), 8'(1 << k));
            irq_n[k] = 1; cyc(1); wr(OFS_CONTROL, 8'h00); cyc(3); chk(8'(eirq), 8'h00);
            wr(OFS_CONTROL, 8'(1 << 2 * k)); rd(OFS_CONTROL, 8'(1 << 2 * k));
            irq_n[k] = 0; cyc(3); irq_n[k] = 1; cyc(3);
            rd(OFS_CONTROL, 8'(3 << 2 * k));
            chk(8'(eirq), 8'(1 << k)); glob = 0; cyc(2); chk(8'(eirq), 8'h00); glob = 1;
            ack[2 + k] = 1; cyc(1); ack = 0; cyc(1); rd(OFS_CONTROL, 8'(1 << 2 * k));
        end
    endtask
    // Reset after a mode write must bring control, mode and Timer1 low back to zero
    task t_reset;
        wr(OFS_MODE, 8'h11); i_resetn = 0; cyc(2); i_resetn = 1;
        rd(OFS_CONTROL, 8'h00); rd(OFS_MODE, 8'h00); rd(OFS_T1_LOW, 8'h00);
    endtask
    initial
    begin
        cyc(10);
        i_resetn = 1;
        t_regs(); t_mode1_irq(); t_mode0_mode2(); t_split(); t_gate(); t_counter(); t_ext(); t_reset();
        tally_and_finish();
    end
    initial
    begin
        repeat (50000) @(posedge i_clk);
        failures++;
        tally_and_finish();
    end
endmodule // dual_timer_counter_tb_top
`default_nettype wire
